// ===== ipd_power_ctrl.sv
// Idle and power-down controller with an AXI4-Lite register port.
// Assumes CPU, port and interrupt logic share clk; rstPin is async.
//
// Overview of operation
// [R1] Idle gates CPU clock, peripherals keep running
// [R2] Deep sleep stops the oscillator entirely
// [R3] Idle-setting write is the last before idle
// [R4] CPU state frozen while idle
// [R5] Idle holds port levels, strobes high
// [R6] Enabled interrupt clears idle bit, resumes
// [R7] Two general flags beside the mode bits
// [R8] Outside holds reset two machine cycles
// [R9] Reset pin clears idle bit directly
// [R10] RAM blocked until internal reset starts
// [R11] Power-down keeps RAM and registers
// [R12] Power-down drives latches, strobes low
// [R13] Only reset leaves power-down, oscillator settles
// [R14] Reset after power-down keeps RAM
// [R15] External memory: port 0 floats, port 2
// [R16] Internal reset loads ports and stack pointer
// [R17] Reset pin sampled once per machine cycle
// [R18] Both bits set means power-down wins
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ipd_power_ctrl #(
  parameter int SETTLE_CYC = ipd_pkg::SETTLE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire ipd_pkg::ipd_addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire ipd_pkg::ipd_word_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire ipd_pkg::ipd_addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output ipd_pkg::ipd_word_t s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rstPin,
  input wire logic irqWake,
  input wire logic extMem,
  input wire ipd_pkg::ipd_byte_t cpuP0,
  input wire logic cpuP0Oe,
  input wire ipd_pkg::ipd_byte_t cpuP1,
  input wire ipd_pkg::ipd_byte_t cpuP2,
  input wire ipd_pkg::ipd_byte_t cpuP3,
  input wire ipd_pkg::ipd_byte_t latchP0,
  input wire ipd_pkg::ipd_byte_t latchP1,
  input wire ipd_pkg::ipd_byte_t latchP2,
  input wire ipd_pkg::ipd_byte_t latchP3,
  input wire ipd_pkg::ipd_byte_t addrHigh,
  input wire logic cpuAle,
  input wire logic cpuProgFetchStrobeN,
  output logic cpuClkEn_q,
  output logic periphClkEn_q,
  output logic oscRun_q,
  output logic ramBlock_q,
  output logic sfrInit_q,
  output ipd_pkg::ipd_byte_t stackInit_q,
  output ipd_pkg::ipd_byte_t p0Out_q,
  output logic p0Oe_q,
  output ipd_pkg::ipd_byte_t p1Out_q,
  output ipd_pkg::ipd_byte_t p2Out_q,
  output ipd_pkg::ipd_byte_t p3Out_q,
  output logic aleOut_q,
  output logic progFetchStrobeN_q
);
  import ipd_pkg::*;

  // ********************************
  // Reset pin sampling
  // ********************************
  logic [1:0] pinSync_q;
  logic [3:0] mcPhase_q;
  logic [1:0] hits_q;
  ipd_state_t st_q;
  ipd_state_t st_d;
  logic [31:0] settleCnt_q;
  logic [3:0] pwr_q;
  logic [3:0] pwr_d;

  wire pinLvl = pinSync_q[1];
  wire frozen = (st_q == ST_PDOWN);
  // [R17] once per machine cycle
  wire mcSample = !frozen && (mcPhase_q == SAMPLE_PHASE);
  wire pinHeld = (hits_q == RST_HOLD_MC);
  wire settleDone = (settleCnt_q == 32'(SETTLE_CYC - 1));

  // Two-stage synchroniser for the pin
  always_ff @(posedge clk) begin
    if (rst) pinSync_q <= 2'h0;
    else pinSync_q <= {pinSync_q[0], rstPin};
  end

  // [R2] phase counter stops
  always_ff @(posedge clk) begin
    if (rst) mcPhase_q <= 4'h0;
    else if (!frozen) mcPhase_q <= (mcPhase_q == MC_LAST) ? 4'h0 : mcPhase_q + 4'h1;
  end

  // [R8] count held samples
  always_ff @(posedge clk) begin
    if (rst) hits_q <= 2'h0;
    else if (mcSample) hits_q <= !pinLvl ? 2'h0 : (pinHeld ? hits_q : hits_q + 2'h1);
  end

  // ********************************
  // AXI4-Lite slave
  // ********************************
  ipd_addr_t awAddr_q;
  ipd_word_t wData_q;
  logic wStrb0_q;

  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire wrFire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wrPwr = wrFire && (awAddr_q == PWR_CTRL_OFF);
  wire wrOk = wrPwr || (awAddr_q == STATUS_OFF);
  wire [2:0] stCode = st_q;
  wire [31:0] statusWord = {26'h0, oscRun_q, ramBlock_q, 1'b0, stCode};
  wire rdPwr = (s_axi_araddr == PWR_CTRL_OFF);
  wire rdStat = (s_axi_araddr == STATUS_OFF);
  wire [31:0] rdWord = rdPwr ? {28'h0, pwr_q} : (rdStat ? statusWord : 32'h0);

  // Address and data captured in either order
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (awTake) s_axi_awready <= 1'b0;
      if (wTake) s_axi_wready <= 1'b0;
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrOk ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write payload holding registers
  always_ff @(posedge clk) begin
    if (rst) begin
      awAddr_q <= 4'h0;
      wData_q <= 32'h0;
      wStrb0_q <= 1'b0;
    end else begin
      if (awTake) awAddr_q <= s_axi_awaddr;
      if (wTake) wData_q <= s_axi_wdata;
      if (wTake) wStrb0_q <= s_axi_wstrb[0];
    end
  end

  // Read channel, answer one cycle after address
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (arTake) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdWord;
      s_axi_rresp <= (rdPwr || rdStat) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ********************************
  // Power control register
  // ********************************
  wire idleWake = (st_q == ST_IDLE) && (irqWake || pinLvl);

  // Mode bits and general flags
  always_comb begin
    pwr_d = pwr_q;
    // [R6] [R9] hardware clear
    if (idleWake) pwr_d[IDLE_BIT] = 1'b0;
    // [R7] flags written with mode
    if (wrPwr && wStrb0_q) pwr_d = wData_q[3:0];
    // [R16] cleared by init
    if (st_q == ST_INIT) pwr_d = PWR_CTRL_RST;
  end

  always_ff @(posedge clk) begin
    if (rst) pwr_q <= PWR_CTRL_RST;
    else pwr_q <= pwr_d;
  end

  // ********************************
  // Mode sequencer
  // ********************************
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_RUN: begin
        // [R18] power-down before idle
        if (pinHeld) st_d = ST_INIT;
        else if (pwr_q[SLEEP_BIT]) st_d = ST_PDOWN;
        else if (pwr_q[IDLE_BIT]) st_d = ST_IDLE;
      end
      ST_IDLE: begin
        // [R9] pin ends idle
        if (pinLvl) st_d = ST_WAKE;
        else if (irqWake) st_d = ST_RUN;
      end
      ST_WAKE: begin
        // [R10] until reset takes over
        if (pinHeld) st_d = ST_INIT;
        else if (mcSample && !pinLvl) st_d = ST_RUN;
      end
      ST_PDOWN: begin
        // [R13] only reset exits
        if (pinLvl) st_d = ST_SETTLE;
      end
      ST_SETTLE: begin
        if (settleDone) st_d = ST_INIT;
      end
      ST_INIT: begin
        if (mcSample && !pinLvl) st_d = ST_RUN;
      end
      default: st_d = ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) st_q <= ST_RUN;
    else st_q <= st_d;
  end

  // [R13] oscillator settle count
  always_ff @(posedge clk) begin
    if (rst) settleCnt_q <= 32'h0;
    else settleCnt_q <= (st_q == ST_SETTLE) ? settleCnt_q + 32'h1 : 32'h0;
  end

  // ********************************
  // Clocks, strobes and pins
  // ********************************
  // Port value for the coming state
  function automatic ipd_byte_t portNext(input ipd_state_t s, input ipd_byte_t cpu,
                                         input ipd_byte_t latch, input ipd_byte_t cur);
    ipd_byte_t v;
    v = cpu;
    if (s == ST_IDLE) v = cur;
    else if (s == ST_PDOWN || s == ST_SETTLE) v = latch;
    else if (s == ST_INIT) v = PORT_RST;
    return v;
  endfunction

  wire nIdle = (st_d == ST_IDLE);
  wire nDown = (st_d == ST_PDOWN) || (st_d == ST_SETTLE);
  wire nInit = (st_d == ST_INIT);
  wire nFloat = extMem && (nIdle || nDown);

  // [R1] [R2] [R3] [R4] clock gates
  always_ff @(posedge clk) begin
    if (rst) begin
      cpuClkEn_q <= 1'b1;
      periphClkEn_q <= 1'b1;
      oscRun_q <= 1'b1;
    end else begin
      cpuClkEn_q <= !(nIdle || nDown);
      periphClkEn_q <= !nDown;
      oscRun_q <= (st_d != ST_PDOWN);
    end
  end

  // [R10] [R14] RAM kept, init flags
  always_ff @(posedge clk) begin
    if (rst) begin
      ramBlock_q <= 1'b0;
      sfrInit_q <= 1'b0;
      stackInit_q <= 8'h00;
    end else begin
      ramBlock_q <= (st_d == ST_WAKE);
      sfrInit_q <= nInit;
      stackInit_q <= nInit ? SP_RST : 8'h00;
    end
  end

  // [R5] [R12] strobe levels
  always_ff @(posedge clk) begin
    if (rst) begin
      aleOut_q <= 1'b1;
      progFetchStrobeN_q <= 1'b1;
    end else begin
      aleOut_q <= nDown ? 1'b0 : (nIdle ? 1'b1 : cpuAle);
      progFetchStrobeN_q <= nDown ? 1'b0 : (nIdle ? 1'b1 : cpuProgFetchStrobeN);
    end
  end

  // [R11] [R15] [R16] port drive
  always_ff @(posedge clk) begin
    if (rst) begin
      p0Out_q <= PORT_RST;
      p0Oe_q <= 1'b0;
      p1Out_q <= PORT_RST;
      p2Out_q <= PORT_RST;
      p3Out_q <= PORT_RST;
    end else begin
      p0Out_q <= portNext(st_d, cpuP0, latchP0, p0Out_q);
      p0Oe_q <= (nFloat || nInit) ? 1'b0 : (nIdle ? p0Oe_q : (nDown || cpuP0Oe));
      p1Out_q <= portNext(st_d, cpuP1, latchP1, p1Out_q);
      p2Out_q <= (extMem && nIdle) ? addrHigh : portNext(st_d, cpuP2, latchP2, p2Out_q);
      p3Out_q <= portNext(st_d, cpuP3, latchP3, p3Out_q);
    end
  end

  // ********************************
  // Assertions
  // ********************************
  idle_gate_a: assert property (@(posedge clk) disable iff (rst) // [R1]
    (st_q == ST_IDLE) |-> (!cpuClkEn_q && periphClkEn_q && oscRun_q))
    else $error("idle clock gating wrong");

  osc_stop_a: assert property (@(posedge clk) disable iff (rst) // [R2]
    (st_q == ST_PDOWN) |-> (!oscRun_q && !periphClkEn_q && !cpuClkEn_q))
    else $error("oscillator not stopped");

  idle_entry_a: assert property (@(posedge clk) disable iff (rst) // [R3]
    (wrPwr && wStrb0_q && wData_q[1:0] == 2'h1 && st_q == ST_RUN && hits_q == 2'h0)
    |=> ##1 (st_q == ST_IDLE && !cpuClkEn_q))
    else $error("idle not entered after write");

  idle_pins_a: assert property (@(posedge clk) disable iff (rst) // [R5]
    (st_q == ST_IDLE && $past(st_q) == ST_IDLE)
    |-> (aleOut_q && progFetchStrobeN_q && $stable(p1Out_q) && $stable(p3Out_q)))
    else $error("idle pins moved");

  irq_wake_a: assert property (@(posedge clk) disable iff (rst) // [R6]
    (st_q == ST_IDLE && irqWake && !pinLvl)
    |=> (st_q == ST_RUN && !pwr_q[IDLE_BIT] && cpuClkEn_q))
    else $error("interrupt did not end idle");

  pin_clear_a: assert property (@(posedge clk) disable iff (rst) // [R9]
    (st_q == ST_IDLE && pinLvl) |=> (st_q == ST_WAKE && !pwr_q[IDLE_BIT]))
    else $error("pin did not clear idle");

  ram_block_a: assert property (@(posedge clk) disable iff (rst) // [R10]
    (st_q == ST_WAKE) |-> (ramBlock_q && cpuClkEn_q && !sfrInit_q))
    else $error("RAM not blocked in wake");

  pd_drive_a: assert property (@(posedge clk) disable iff (rst) // [R12]
    (st_q == ST_PDOWN && $past(st_q) == ST_PDOWN)
    |-> (!aleOut_q && !progFetchStrobeN_q && p1Out_q == $past(latchP1)))
    else $error("power-down pins wrong");

  settle_len_a: assert property (@(posedge clk) disable iff (rst) // [R13]
    ($past(st_q) == ST_SETTLE && st_q == ST_INIT)
    |-> ($past(settleCnt_q) == 32'(SETTLE_CYC - 1)))
    else $error("settle time wrong");

  ext_float_a: assert property (@(posedge clk) disable iff (rst) // [R15]
    (extMem && st_q == ST_PDOWN) |-> (!p0Oe_q && p2Out_q == $past(latchP2)))
    else $error("external memory pins wrong");

  init_value_a: assert property (@(posedge clk) disable iff (rst) // [R16]
    (st_q == ST_INIT) |-> (sfrInit_q && stackInit_q == SP_RST && p3Out_q == PORT_RST))
    else $error("init values wrong");

  sample_phase_a: assert property (@(posedge clk) disable iff (rst) // [R17]
    $changed(hits_q) |-> ($past(mcPhase_q) == SAMPLE_PHASE))
    else $error("pin sampled off phase");

  both_bits_a: assert property (@(posedge clk) disable iff (rst) // [R18]
    (wrPwr && wStrb0_q && wData_q[1:0] == 2'h3 && st_q == ST_RUN && hits_q == 2'h0)
    |=> ##1 (st_q == ST_PDOWN))
    else $error("power-down did not win");
endmodule
`default_nettype wire

// ===== ipd_pkg.sv
// Constants and types for the idle and power-down controller.
// Assumes one 250 MHz clock that also stands for the oscillator.
`default_nettype none
package ipd_pkg;
  typedef logic [7:0] ipd_byte_t;
  typedef logic [31:0] ipd_word_t;
  typedef logic [3:0] ipd_addr_t;
  typedef enum logic [2:0] {
    ST_RUN, ST_IDLE, ST_PDOWN, ST_SETTLE, ST_WAKE, ST_INIT
  } ipd_state_t;
  // Register byte offsets
  localparam ipd_addr_t PWR_CTRL_OFF = 4'h0;
  localparam ipd_addr_t STATUS_OFF = 4'h4;
  // Power control register fields
  localparam int IDLE_BIT = 0;
  localparam int SLEEP_BIT = 1;
  localparam int GF0_BIT = 2;
  localparam int GF1_BIT = 3;
  localparam logic [3:0] PWR_CTRL_RST = 4'h0;
  // Values loaded by the internal reset sequence
  localparam ipd_byte_t SP_RST = 8'h07;
  localparam ipd_byte_t PORT_RST = 8'hff;
  // Machine cycle of twelve oscillator periods
  localparam int MC_LEN = 12;
  localparam logic [3:0] MC_LAST = 4'(MC_LEN - 1);
  localparam logic [3:0] SAMPLE_PHASE = 4'h9;
  localparam logic [1:0] RST_HOLD_MC = 2'h2;
  // Oscillator settle time after leaving power-down
  localparam int CLK_MHZ = 250;
  localparam int SETTLE_TIME_US = 10000;
  localparam int SETTLE_CYC = SETTLE_TIME_US * CLK_MHZ;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ===== ipd_core_model.sv
// Behavioural core and port latches on the far side of the controller.
// Assumes clk stands for the oscillator and cpuClkEn gates the core.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Core model
// ****************************************
module ipd_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic cpuClkEn,
  output ipd_pkg::ipd_byte_t cpuP0,
  output logic cpuP0Oe,
  output ipd_pkg::ipd_byte_t cpuP1,
  output ipd_pkg::ipd_byte_t cpuP2,
  output ipd_pkg::ipd_byte_t cpuP3,
  output ipd_pkg::ipd_byte_t latchP0,
  output ipd_pkg::ipd_byte_t latchP1,
  output ipd_pkg::ipd_byte_t latchP2,
  output ipd_pkg::ipd_byte_t latchP3,
  output ipd_pkg::ipd_byte_t addrHigh,
  output logic cpuAle,
  output logic cpuProgFetchStrobeN
);
  import ipd_pkg::*;
  ipd_byte_t step_q;
  // core state advances on enabled clocks only
  always_ff @(posedge clk) begin
    if (rst) begin
      step_q <= 8'h00;
    end else if (cpuClkEn) begin
      step_q <= step_q + 8'h01;
    end
  end
  // Port and latch values move every running cycle so a missed hold shows
  assign cpuP0 = step_q;
  assign cpuP0Oe = 1'b1;
  assign cpuP1 = step_q ^ 8'h11;
  assign cpuP2 = ~step_q;
  assign cpuP3 = step_q + 8'h03;
  assign latchP0 = step_q ^ 8'h5a;
  assign latchP1 = step_q ^ 8'ha5;
  assign latchP2 = step_q ^ 8'h3c;
  assign latchP3 = step_q ^ 8'hc3;
  assign addrHigh = step_q ^ 8'h96;
  assign cpuAle = step_q[0]; // Low half the time, unlike idle
  assign cpuProgFetchStrobeN = ~step_q[1];
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the idle and power-down controller.
// Assumes ipd_pkg, ipd_power_ctrl and ipd_core_model compile first.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bench
// ****************************************
module tb;
  import ipd_pkg::*;
  localparam int SETTLE = 20;
  typedef struct packed {
    ipd_addr_t a; ipd_word_t wd; logic [1:0] br; ipd_word_t rd; logic [1:0] rr;
  } ipd_row_t;
  logic clk, rst, rstPin, irqWake, extMem, cpuP0Oe, cpuAle, cpuProgFetchStrobeN;
  ipd_addr_t s_axi_awaddr, s_axi_araddr;
  ipd_word_t s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
  ipd_byte_t cpuP0, cpuP1, cpuP2, cpuP3, latchP0, latchP1, latchP2, latchP3;
  ipd_byte_t addrHigh, stackInit_q, p0Out_q, p1Out_q, p2Out_q, p3Out_q, held;
  logic cpuClkEn_q, periphClkEn_q, oscRun_q, ramBlock_q, sfrInit_q, p0Oe_q;
  logic aleOut_q, progFetchStrobeN_q;
  int fail_count, samples_checked, n;
  ipd_row_t rows [4] = '{
    '{PWR_CTRL_OFF, 32'h0000000c, RESP_OKAY, 32'h0000000c, RESP_OKAY},
    '{4'h8, 32'h00000005, RESP_SLVERR, 32'h00000000, RESP_SLVERR},
    '{4'hc, 32'h0000000f, RESP_SLVERR, 32'h00000000, RESP_SLVERR},
    '{PWR_CTRL_OFF, 32'h00000000, RESP_OKAY, 32'h00000000, RESP_OKAY}};

  ipd_power_ctrl #(.SETTLE_CYC(SETTLE)) i_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rstPin, .irqWake, .extMem,
    .cpuP0, .cpuP0Oe, .cpuP1, .cpuP2, .cpuP3, .latchP0, .latchP1, .latchP2, .latchP3,
    .addrHigh, .cpuAle, .cpuProgFetchStrobeN, .cpuClkEn_q, .periphClkEn_q, .oscRun_q,
    .ramBlock_q, .sfrInit_q, .stackInit_q, .p0Out_q, .p0Oe_q, .p1Out_q, .p2Out_q,
    .p3Out_q, .aleOut_q, .progFetchStrobeN_q);
  ipd_core_model i_core (.clk, .rst, .cpuClkEn(cpuClkEn_q), .cpuP0, .cpuP0Oe, .cpuP1,
    .cpuP2, .cpuP3, .latchP0, .latchP1, .latchP2, .latchP3, .addrHigh, .cpuAle,
    .cpuProgFetchStrobeN);

  // Clock of 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compare and count
  task automatic chk(input ipd_word_t got, input ipd_word_t exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A wait that ran out of cycles ends the run
  task automatic lim(input int cnt, input int max);
    if (cnt >= max) begin
      chk(32'(cnt), 32'(max - 1));
      report_and_stop();
    end
  endtask

  // Register write: address and data offered together
  task automatic axi_wr(input ipd_addr_t a, input ipd_word_t d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    lim(n, 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Register read
  task automatic axi_rd(input ipd_addr_t a, output ipd_word_t d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    lim(n, 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Main sequence
  initial begin
    {rst, rstPin, irqWake, extMem, s_axi_awvalid, s_axi_wvalid} = 6'b100000;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'b000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h00, 32'h0, 4'hf};
    fail_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    chk({26'h0, cpuClkEn_q, oscRun_q, p0Oe_q, aleOut_q, progFetchStrobeN_q, s_axi_bvalid},
        32'h36);
    chk({16'h0, p1Out_q, stackInit_q}, 32'hff00);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      axi_wr(rows[i].a, rows[i].wd, br);
      axi_rd(rows[i].a, rd, rr);
      chk(rd, rows[i].rd);
      chk({28'h0, br, rr}, {28'h0, rows[i].br, rows[i].rr});
    end
    @(posedge clk);
    axi_rd(STATUS_OFF, rd, rr);
    chk(rd, 32'h20);
    // Write with its low byte lane off leaves modes and flags alone
    s_axi_wstrb <= 4'h0;
    axi_wr(PWR_CTRL_OFF, 32'h0000000f, br);
    s_axi_wstrb <= 4'hf;
    axi_rd(PWR_CTRL_OFF, rd, rr);
    chk(rd, 32'h0);
    chk({30'h0, br}, {30'h0, RESP_OKAY});
    // Idle, left by interrupt then by the reset pin
    for (int m = 0; m < 2; m++) begin
      extMem <= m[0];
      axi_wr(PWR_CTRL_OFF, 32'hd, br);
      for (n = 0; n < 20 && cpuClkEn_q !== 1'b0; n++) @(posedge clk);
      lim(n, 20);
      held = p1Out_q;
      repeat (8) @(posedge clk);
      chk({26'h0, cpuClkEn_q, periphClkEn_q, oscRun_q, aleOut_q, progFetchStrobeN_q, p0Oe_q},
          {26'h0, 5'b01111, ~m[0]});
      chk({16'h0, p1Out_q, held}, {16'h0, held, held});
      if (m == 1) chk({24'h0, p2Out_q}, {24'h0, addrHigh});
      axi_rd(STATUS_OFF, rd, rr);
      chk(rd, 32'h21);
      if (m == 0) begin
        irqWake <= 1'b1;
        for (n = 0; n < 10 && cpuClkEn_q !== 1'b1; n++) @(posedge clk);
        lim(n, 10);
        irqWake <= 1'b0;
        axi_rd(PWR_CTRL_OFF, rd, rr);
        chk(rd, 32'hc);
      end else begin
        // pin held until two machine-cycle samples have seen it high
        rstPin <= 1'b1;
        for (n = 0; n < 40 && ramBlock_q !== 1'b1; n++) @(posedge clk);
        lim(n, 40);
        chk({30'h0, cpuClkEn_q, ramBlock_q}, 32'h3);
        for (n = 0; n < 60 && sfrInit_q !== 1'b1; n++) @(posedge clk);
        lim(n, 60);
        chk({8'h0, stackInit_q, p1Out_q, p3Out_q}, {8'h0, SP_RST, PORT_RST, PORT_RST});
        rstPin <= 1'b0;
        for (n = 0; n < 40 && sfrInit_q !== 1'b0; n++) @(posedge clk);
        lim(n, 40);
        axi_rd(PWR_CTRL_OFF, rd, rr);
        chk(rd, 32'h0);
      end
    end
    // Power-down, second pass with both mode bits set
    for (int m = 0; m < 2; m++) begin
      extMem <= m[0];
      axi_wr(PWR_CTRL_OFF, {28'h0, 3'h7, m[0]}, br);
      for (n = 0; n < 20 && oscRun_q !== 1'b0; n++) @(posedge clk);
      lim(n, 20);
      repeat (2) @(posedge clk);
      chk({27'h0, cpuClkEn_q, periphClkEn_q, aleOut_q, progFetchStrobeN_q, p0Oe_q},
          {27'h0, 4'h0, ~m[0]});
      chk({8'h0, p1Out_q, p2Out_q, p3Out_q}, {8'h0, latchP1, latchP2, latchP3});
      if (m == 0) chk({24'h0, p0Out_q}, {24'h0, latchP0});
      irqWake <= 1'b1;
      repeat (10) @(posedge clk);
      chk({31'h0, oscRun_q}, 32'h0);
      irqWake <= 1'b0;
      // pin held through the oscillator settle time
      rstPin <= 1'b1;
      for (n = 0; n < 100 && oscRun_q !== 1'b1; n++) @(posedge clk);
      lim(n, 100);
      // Oscillator restarts at once; init waits out the settle count
      for (n = 0; n < 100 && sfrInit_q !== 1'b1; n++) @(posedge clk);
      lim(n, 100);
      chk(32'(n), 32'(SETTLE));
      rstPin <= 1'b0;
      for (n = 0; n < 40 && sfrInit_q !== 1'b0; n++) @(posedge clk);
      lim(n, 40);
      axi_rd(PWR_CTRL_OFF, rd, rr);
      chk(rd, 32'h0);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
